// file: fsp_pkg.sv
// Shared constants and types for the flash self-program sequencer
package fsp_pkg;

    // Clock and timing, times in microseconds
    localparam int CLK_HZ             = 20_000_000;
    localparam int CLK_MHZ            = CLK_HZ / 1_000_000;
    localparam int STEP_COUNT         = 5000;
    localparam int PROG_FIXED_US      = 2000;
    localparam int ERASE_FIXED_US     = 9000;
    localparam int POWERON_INHIBIT_US = 20000;
    localparam int PROG_FIXED_CYC     = PROG_FIXED_US * CLK_MHZ;
    localparam int ERASE_FIXED_CYC    = ERASE_FIXED_US * CLK_MHZ;
    localparam int POWERON_CYC        = POWERON_INHIBIT_US * CLK_MHZ;
    localparam int DIV_MAX            = 16;

    // Register byte offsets
    localparam logic [3:0] OFS_TARGET_ADDR = 4'h0;
    localparam logic [3:0] OFS_UNLOCK      = 4'h4;
    localparam logic [3:0] OFS_CONTROL     = 4'h8;
    localparam logic [3:0] OFS_STATUS      = 4'hc;

    // Control register fields
    localparam int         CTRL_PGM_BIT   = 0;
    localparam int         CTRL_ERS_BIT   = 1;
    localparam int         CTRL_FCLK_LSB  = 3;
    localparam logic [7:0] CTRL_ONES      = 8'he4;
    localparam logic [1:0] FCLK_RESET     = 2'h0;

    // Status register fields
    localparam int STAT_BUSY_BIT    = 0;
    localparam int STAT_HOLD_BIT    = 1;
    localparam int STAT_INHIBIT_BIT = 2;
    localparam int STAT_ACC_BIT     = 3;
    localparam int STAT_RSTPEND_BIT = 4;

    // Unlock key nibbles
    localparam logic [3:0] UNLOCK_KEY1 = 4'h5;
    localparam logic [3:0] UNLOCK_KEY2 = 4'ha;

    // Address layout
    localparam logic [15:0] ADDR_ONES      = 16'h003f;
    localparam logic [15:0] RAM_STAGE_BASE = 16'h0300;
    localparam logic [15:0] RAM_STAGE_LAST = 16'h033f;
    localparam int          UNIT_LSB       = 6;
    localparam int          SECTOR_LSB     = 10;
    localparam logic [6:0]  UNIT_BYTES     = 7'h40;
    localparam logic [15:0] ADDR_RESET     = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARM,
        ST_COPY,
        ST_WAIT,
        ST_DONE
    } fsp_state_e;

endpackage : fsp_pkg

// file: fsp_tmr_if.sv
// Link between the sequencer and its operation timer
`timescale 1ns/10ps
interface fsp_tmr_if;
    logic       start;
    logic       erase;
    logic [1:0] div_sel;
    logic       done;

    modport ctl (output start, output erase, output div_sel, input done);
    modport tmr (input start, input erase, input div_sel, output done);
endinterface : fsp_tmr_if

// file: fsp_op_timer.sv
// Operation timer: divided-clock step count plus a fixed tail
`timescale 1ns/10ps
module fsp_op_timer #(
    parameter int STEP_COUNT      = fsp_pkg::STEP_COUNT,
    parameter int PROG_FIXED_CYC  = fsp_pkg::PROG_FIXED_CYC,
    parameter int ERASE_FIXED_CYC = fsp_pkg::ERASE_FIXED_CYC
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Sequencer link
    fsp_tmr_if.tmr    tmr
);
    localparam int SW = $clog2(STEP_COUNT + 1);
    localparam int FW = $clog2(ERASE_FIXED_CYC + PROG_FIXED_CYC + 1);

    logic          run_q;
    logic          tail_q;
    logic          erase_q;
    logic [1:0]    sel_q;
    logic [4:0]    pre_q;
    logic [4:0]    div_n;
    logic [SW-1:0] step_q;
    logic [FW-1:0] rem_q;
    logic          done_q;
    logic          tick;
    logic          step_done;

    // Divider factor 16, 8, 4 or 2; latched so a late write cannot stretch it
    assign div_n     = 5'(fsp_pkg::DIV_MAX) >> sel_q;
    assign tick      = run_q && !tail_q && (pre_q == div_n - 5'h01);
    assign step_done = tick && (step_q == SW'(STEP_COUNT - 1));
    assign tmr.done  = done_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            run_q   <= 1'b0;
            tail_q  <= 1'b0;
            erase_q <= 1'b0;
            sel_q   <= 2'h0;
            pre_q   <= 5'h00;
            step_q  <= '0;
            rem_q   <= '0;
            done_q  <= 1'b0;
        end else if (tmr.start) begin
            run_q   <= 1'b1;
            tail_q  <= 1'b0;
            erase_q <= tmr.erase;
            sel_q   <= tmr.div_sel;
            pre_q   <= 5'h00;
            step_q  <= '0;
            done_q  <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (run_q && !tail_q) begin
                pre_q <= tick ? 5'h00 : pre_q + 5'h01;
                if (step_done) begin
                    tail_q <= 1'b1;
                    rem_q  <= erase_q ? FW'(ERASE_FIXED_CYC - 1)
                                      : FW'(PROG_FIXED_CYC - 1);
                end else if (tick) begin
                    step_q <= step_q + SW'(1);
                end
            end else if (run_q) begin
                if (rem_q == '0) begin
                    run_q  <= 1'b0;
                    tail_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    rem_q <= rem_q - FW'(1);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    int unsigned cyc_q;
    int unsigned expect_cyc;

    assign expect_cyc = int'(div_n) * STEP_COUNT
                      + (erase_q ? ERASE_FIXED_CYC : PROG_FIXED_CYC);

    always_ff @(posedge i_clk) begin
        if (i_rst || tmr.start) begin
            cyc_q <= 0;
        end else if (run_q) begin
            cyc_q <= cyc_q + 1;
        end
    end

    chk_duration_exact: assert property (
        @(posedge i_clk) disable iff (i_rst)
        done_q |-> cyc_q == expect_cyc
    ) else $error("Operation time differs from formula");

endmodule : fsp_op_timer

// file: fsp_sequencer.sv
// Flash self-program sequencer with Avalon-MM register slave
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/10ps
module fsp_sequencer #(
    parameter int POWERON_CYC     = fsp_pkg::POWERON_CYC,
    parameter int PROG_FIXED_CYC  = fsp_pkg::PROG_FIXED_CYC,
    parameter int ERASE_FIXED_CYC = fsp_pkg::ERASE_FIXED_CYC
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Avalon-MM slave
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // CPU side
    input  wire logic        i_instr_retired,
    input  wire logic        i_external_reset_pin,
    output logic             o_cpu_hold,
    output logic             o_irq_defer,
    output logic             o_core_reset,
    // Staging RAM read port
    output logic             o_ram_rd,
    output logic      [15:0] o_ram_addr,
    input  wire logic [7:0]  i_ram_rdata,
    // Flash array port
    output logic             o_flash_wr,
    output logic             o_flash_erase,
    output logic      [15:0] o_flash_addr,
    output logic      [7:0]  o_flash_wdata
);
    localparam int PW = $clog2(POWERON_CYC + 1);

    fsp_tmr_if tmr_link ();

    fsp_pkg::fsp_state_e state_q;

    logic          ack_q;
    logic [31:0]   rdata_q;
    logic [31:0]   rdata_d;
    logic          wr_ok;
    logic          addr_ok;
    logic [15:0]   target_q;
    logic          stage_q;
    logic          acc_q;
    logic          pgm_q;
    logic          ers_q;
    logic [1:0]    fclk_q;
    logic          hold_q;
    logic          pend_q;
    logic          core_rst_q;
    logic [PW-1:0] pon_q;
    logic          inhibit;
    logic          busy;
    logic          ctrl_wr;
    logic          ctrl_take;
    logic          both_set;
    logic          start_go;
    logic [6:0]    cnt_q;
    logic          ram_rd_q;
    logic [15:0]   ram_addr_q;
    logic          rd_d1_q;
    logic [5:0]    ofs_d1_q;
    logic          fl_wr_q;
    logic          fl_er_q;
    logic [15:0]   fl_addr_q;
    logic [7:0]    fl_data_q;
    logic          tmr_start_q;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait state, read data registered

    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
    assign o_avs_readdata    = rdata_q;
    assign addr_ok           = (i_avs_address[1:0] == 2'h0);
    assign wr_ok             = i_avs_write && ack_q && addr_ok;
    assign busy              = (state_q != fsp_pkg::ST_IDLE);
    assign inhibit           = (pon_q != '0);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (i_avs_read || i_avs_write) && !ack_q;
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (addr_ok) begin
            unique case (i_avs_address)
                fsp_pkg::OFS_TARGET_ADDR:
                    rdata_d[15:0] = target_q | fsp_pkg::ADDR_ONES;
                fsp_pkg::OFS_UNLOCK:
                    rdata_d[0] = acc_q;
                fsp_pkg::OFS_CONTROL: begin
                    rdata_d[7:0] = fsp_pkg::CTRL_ONES;
                    rdata_d[fsp_pkg::CTRL_PGM_BIT] = pgm_q;
                    rdata_d[fsp_pkg::CTRL_ERS_BIT] = ers_q;
                    rdata_d[fsp_pkg::CTRL_FCLK_LSB +: 2] = fclk_q;
                end
                fsp_pkg::OFS_STATUS: begin
                    rdata_d[fsp_pkg::STAT_BUSY_BIT]    = busy;
                    rdata_d[fsp_pkg::STAT_HOLD_BIT]    = hold_q;
                    rdata_d[fsp_pkg::STAT_INHIBIT_BIT] = inhibit;
                    rdata_d[fsp_pkg::STAT_ACC_BIT]     = acc_q;
                    rdata_d[fsp_pkg::STAT_RSTPEND_BIT] = pend_q;
                end
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (i_avs_read && !ack_q) begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Target address; frozen while an operation runs

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            target_q <= fsp_pkg::ADDR_RESET;
        end else if (wr_ok && !busy
                     && i_avs_address == fsp_pkg::OFS_TARGET_ADDR) begin
            if (i_avs_byteenable[0]) begin
                target_q[7:0] <= i_avs_writedata[7:0];
            end
            if (i_avs_byteenable[1]) begin
                target_q[15:8] <= i_avs_writedata[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Unlock key; any other write between the two halves breaks it

    assign ctrl_wr   = wr_ok && i_avs_byteenable[0]
                     && i_avs_address == fsp_pkg::OFS_CONTROL;
    assign ctrl_take = ctrl_wr && acc_q && !busy;
    assign both_set  = i_avs_writedata[fsp_pkg::CTRL_PGM_BIT]
                     && i_avs_writedata[fsp_pkg::CTRL_ERS_BIT];

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stage_q <= 1'b0;
            acc_q   <= 1'b0;
        end else begin
            if (state_q == fsp_pkg::ST_DONE || (ctrl_take && both_set)) begin
                acc_q <= 1'b0;
            end
            if (wr_ok && i_avs_address == fsp_pkg::OFS_UNLOCK
                && i_avs_byteenable[0]) begin
                if (stage_q
                    && i_avs_writedata[3:0] == fsp_pkg::UNLOCK_KEY2) begin
                    acc_q   <= 1'b1;
                    stage_q <= 1'b0;
                end else begin
                    stage_q <= (i_avs_writedata[3:0] == fsp_pkg::UNLOCK_KEY1);
                end
            end else if (wr_ok) begin
                stage_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register: start flags and divider select

    assign start_go = ctrl_take && !both_set && !inhibit
                   && (i_avs_writedata[fsp_pkg::CTRL_PGM_BIT]
                       || i_avs_writedata[fsp_pkg::CTRL_ERS_BIT]);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pgm_q  <= 1'b0;
            ers_q  <= 1'b0;
            fclk_q <= fsp_pkg::FCLK_RESET;
        end else if (ctrl_take) begin
            fclk_q <= i_avs_writedata[fsp_pkg::CTRL_FCLK_LSB +: 2];
            if (start_go) begin
                pgm_q <= i_avs_writedata[fsp_pkg::CTRL_PGM_BIT];
                ers_q <= i_avs_writedata[fsp_pkg::CTRL_ERS_BIT];
            end
        end else if (state_q == fsp_pkg::ST_DONE) begin
            pgm_q <= 1'b0;
            ers_q <= 1'b0;
        end
    end

    // Power-on programming lockout
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pon_q <= PW'(POWERON_CYC);
        end else if (pon_q != '0) begin
            pon_q <= pon_q - PW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequence control

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q     <= fsp_pkg::ST_IDLE;
            hold_q      <= 1'b0;
            tmr_start_q <= 1'b0;
            fl_er_q     <= 1'b0;
        end else begin
            tmr_start_q <= 1'b0;
            fl_er_q     <= 1'b0;
            unique case (state_q)
                fsp_pkg::ST_IDLE: begin
                    if (start_go) begin
                        state_q <= fsp_pkg::ST_ARM;
                    end
                end
                fsp_pkg::ST_ARM: begin
                    // Hold only once the next instruction has retired
                    if (i_instr_retired) begin
                        hold_q <= 1'b1;
                        if (pgm_q) begin
                            state_q <= fsp_pkg::ST_COPY;
                        end else begin
                            fl_er_q     <= 1'b1;
                            tmr_start_q <= 1'b1;
                            state_q     <= fsp_pkg::ST_WAIT;
                        end
                    end
                end
                fsp_pkg::ST_COPY: begin
                    if (cnt_q == fsp_pkg::UNIT_BYTES && !ram_rd_q
                        && !rd_d1_q) begin
                        tmr_start_q <= 1'b1;
                        state_q     <= fsp_pkg::ST_WAIT;
                    end
                end
                fsp_pkg::ST_WAIT: begin
                    if (tmr_link.done) begin
                        state_q <= fsp_pkg::ST_DONE;
                    end
                end
                fsp_pkg::ST_DONE: begin
                    hold_q  <= 1'b0;
                    state_q <= fsp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign tmr_link.start   = tmr_start_q;
    assign tmr_link.erase   = ers_q;
    assign tmr_link.div_sel = fclk_q;

    fsp_op_timer #(
        .STEP_COUNT      (fsp_pkg::STEP_COUNT),
        .PROG_FIXED_CYC  (PROG_FIXED_CYC),
        .ERASE_FIXED_CYC (ERASE_FIXED_CYC)
    ) u_timer (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .tmr   (tmr_link)
    );

    ////////////////////////////////////////////////////////////////////////
    // RAM to flash copy; RAM data valid the cycle after the read

    always_ff @(posedge i_clk) begin
        if (i_rst || state_q != fsp_pkg::ST_COPY) begin
            cnt_q      <= 7'h00;
            ram_rd_q   <= 1'b0;
            ram_addr_q <= fsp_pkg::RAM_STAGE_BASE;
        end else if (cnt_q != fsp_pkg::UNIT_BYTES) begin
            ram_rd_q   <= 1'b1;
            ram_addr_q <= fsp_pkg::RAM_STAGE_BASE | {10'h000, cnt_q[5:0]};
            cnt_q      <= cnt_q + 7'h01;
        end else begin
            ram_rd_q <= 1'b0;
        end
    end

    // Every byte is written, FFh included, so each counts as programmed
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rd_d1_q   <= 1'b0;
            ofs_d1_q  <= 6'h00;
            fl_wr_q   <= 1'b0;
            fl_addr_q <= 16'h0000;
            fl_data_q <= 8'h00;
        end else begin
            rd_d1_q  <= ram_rd_q;
            ofs_d1_q <= ram_addr_q[5:0];
            fl_wr_q  <= rd_d1_q;
            if (rd_d1_q) begin
                fl_addr_q <= {target_q[15:fsp_pkg::UNIT_LSB], ofs_d1_q};
                fl_data_q <= i_ram_rdata;
            end else if (state_q == fsp_pkg::ST_ARM && ers_q) begin
                fl_addr_q <= {target_q[15:fsp_pkg::SECTOR_LSB], 10'h000};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset pin deferral

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pend_q     <= 1'b0;
            core_rst_q <= 1'b0;
        end else begin
            pend_q     <= busy && (pend_q || i_external_reset_pin);
            core_rst_q <= !busy && (pend_q || i_external_reset_pin);
        end
    end

    assign o_cpu_hold    = hold_q;
    assign o_irq_defer   = busy;
    assign o_core_reset  = core_rst_q;
    assign o_ram_rd      = ram_rd_q;
    assign o_ram_addr    = ram_addr_q;
    assign o_flash_wr    = fl_wr_q;
    assign o_flash_erase = fl_er_q;
    assign o_flash_addr  = fl_addr_q;
    assign o_flash_wdata = fl_data_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_arm_fire;
        state_q == fsp_pkg::ST_ARM && i_instr_retired;
    endsequence

    int unsigned wr_cnt_q;
    always_ff @(posedge i_clk) begin
        if (i_rst || tmr_start_q) begin
            wr_cnt_q <= 0;
        end else if (fl_wr_q) begin
            wr_cnt_q <= wr_cnt_q + 1;
        end
    end

    chk_hold_after_instr: assert property (
        s_arm_fire |=> o_cpu_hold
    ) else $error("Hold not raised after one instruction");
    chk_hold_cause: assert property (
        $rose(o_cpu_hold) |-> $past(i_instr_retired)
    ) else $error("Hold raised without a retired instruction");
    chk_done_clears: assert property (
        $fell(o_cpu_hold) |-> !pgm_q && !ers_q && !acc_q && !busy
    ) else $error("Flags or acceptor left set after completion");
    chk_locked_ctrl: assert property (
        ctrl_wr && !acc_q |=> $stable(pgm_q) && $stable(ers_q)
                              && $stable(fclk_q)
    ) else $error("Control changed without unlock");
    chk_both_none: assert property (
        ctrl_take && both_set |=> state_q == fsp_pkg::ST_IDLE && !acc_q
    ) else $error("Conflicting flags started an operation");
    chk_ram_window: assert property (
        o_ram_rd |-> o_ram_addr >= fsp_pkg::RAM_STAGE_BASE
                  && o_ram_addr <= fsp_pkg::RAM_STAGE_LAST
    ) else $error("RAM read outside staging window");
    chk_unit_addr: assert property (
        o_flash_wr |-> o_flash_addr[15:6] == target_q[15:6]
    ) else $error("Flash write outside target unit");
    chk_unit_count: assert property (
        // Counter clears on the timer start, so look on entry to the wait
        state_q == fsp_pkg::ST_COPY ##1 state_q == fsp_pkg::ST_WAIT
        |-> wr_cnt_q == 64
    ) else $error("Program did not write 64 bytes");
    chk_erase_fire: assert property (
        s_arm_fire ##0 ers_q |=> o_flash_erase ##1 !o_flash_erase
    ) else $error("Erase pulse missing or stretched");
    chk_irq_defer: assert property (
        o_cpu_hold |-> o_irq_defer
    ) else $error("Interrupts not held off during operation");
    chk_reset_defer: assert property (
        busy && $past(busy) |-> !o_core_reset
    ) else $error("Core reset issued during operation");
    chk_inhibit_start: assert property (
        inhibit && state_q == fsp_pkg::ST_IDLE |=> !busy
    ) else $error("Operation started during power-on lockout");
    chk_div_reset: assert property (
        $past(i_rst) |-> fclk_q == 2'h0
    ) else $error("Divider select not cleared by reset");

endmodule : fsp_sequencer

// file: fsp_cpu_ram_model.sv
// Partner model: CPU retire pulses and staging RAM read port
`timescale 1ns/10ps
module fsp_cpu_ram_model (
    // Clock and CPU hold
    input  wire logic        i_clk,
    input  wire logic        i_hold,
    // Staging RAM and retire pulse
    input  wire logic        i_ram_rd,
    input  wire logic [15:0] i_ram_addr,
    output logic             o_retired,
    output logic      [7:0]  o_rdata
);
    logic [1:0] div_q = 2'h0;
    logic       ret_q = 1'b0;
    logic [7:0] dat_q = 8'h00;
    assign o_retired = ret_q;
    assign o_rdata   = dat_q;
    always @(posedge i_clk) begin
        div_q <= div_q + 2'h1;
        // Never enters stop mode, so no standby wait is owed
        // A held CPU retires nothing
        ret_q <= !i_hold && div_q == 2'h0;
        // Stale data inverts so a late sample cannot match
        dat_q <= i_ram_rd ? i_ram_addr[7:0] ^ 8'hc3 : ~dat_q;
    end
endmodule : fsp_cpu_ram_model

// file: flash_self_program_sequencer_tb.sv
// Self-checking bench for the flash self-program sequencer
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module flash_self_program_sequencer_tb;
    logic        i_clk = 1'b0, i_rst = 1'b1, rd = 1'b0, wr = 1'b0, pin = 1'b0;
    logic [3:0]  ad = 4'h0;
    logic [31:0] wd = 32'h0, q;
    logic        ret, hold, defer, crst, rrd, fwr, fer, seen = 1'b0;
    logic [15:0] raddr, faddr;
    logic [7:0]  rdat, fdat;
    logic [31:0] rdout;
    logic        wreq;
    int          n_fail = 0, total_checks = 0, nwr = 0, nret = 0, hcyc = 0;
    int          ner = 0;
    fsp_sequencer #(.POWERON_CYC(50), .PROG_FIXED_CYC(20),
        .ERASE_FIXED_CYC(30)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_avs_address(ad), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(4'h3),
        .o_avs_readdata(rdout), .o_avs_waitrequest(wreq),
        .i_instr_retired(ret), .i_external_reset_pin(pin), .o_cpu_hold(hold),
        .o_irq_defer(defer), .o_core_reset(crst), .o_ram_rd(rrd),
        .o_ram_addr(raddr), .i_ram_rdata(rdat), .o_flash_wr(fwr),
        .o_flash_erase(fer), .o_flash_addr(faddr), .o_flash_wdata(fdat));
    fsp_cpu_ram_model u_far (.i_clk(i_clk), .i_hold(hold), .i_ram_rd(rrd),
        .i_ram_addr(raddr), .o_retired(ret), .o_rdata(rdat));
    initial forever #25 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        if (fwr) begin
            nwr++;
            `CHK(faddr[15:6], 10'h154)
            `CHK(fdat, {2'h0, faddr[5:0]} ^ 8'hc3)
        end
        if (fer) begin
            ner++;
            `CHK(faddr, 16'h5400)
        end
        if (hold) begin
            hcyc++;
            `CHK(crst, 1'b0)
        end
        if (defer && !hold && ret) nret++;
        if (crst) seen = 1'b1;
    end
    task automatic acc(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge i_clk);
        rd <= !w; wr <= w; ad <= a; wd <= d;
        do @(posedge i_clk); while (wreq !== 1'b0);
        q = rdout;
        rd <= 1'b0; wr <= 1'b0;
    endtask : acc
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask : rdc
    task automatic run(input logic [31:0] c, input logic p);
        acc(1'b1, 4'h4, 32'h35); acc(1'b1, 4'h4, 32'h7a);
        hcyc = 0; nret = 0;
        acc(1'b1, 4'h8, c);
        while (hold !== 1'b1) @(posedge i_clk);
        repeat (10) @(posedge i_clk);
        `CHK(defer, 1'b1)
        pin <= p;
        @(posedge i_clk);
        pin <= 1'b0;
        while (hold !== 1'b0) @(posedge i_clk);
        // Divider /2: 5000 steps of two cycles plus the shortened tail
        `CHK(hcyc >= 10020 && hcyc < 10200, 1'b1)
        `CHK(nret, 1)
    endtask : run
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    initial begin
        #(50 * 40000);
        n_fail++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        rdc(4'hc, 32'h4);
        rdc(4'h8, 32'he4);
        rdc(4'h0, 32'h3f);
        // Unlocked start inside the lockout must stay idle
        acc(1'b1, 4'h4, 32'h35);
        acc(1'b1, 4'h4, 32'h7a);
        acc(1'b1, 4'h8, 32'h1a);
        rdc(4'hc, 32'hc);
        acc(1'b1, 4'h8, 32'h03);
        rdc(4'hc, 32'h4);
        $display("test reset and lockout done");
        repeat (60) @(posedge i_clk);
        acc(1'b1, 4'h8, 32'h19);
        rdc(4'h8, 32'he4);
        acc(1'b1, 4'h0, 32'h5500);
        run(32'h19, 1'b0);
        rdc(4'h8, 32'hfc);
        rdc(4'hc, 32'h0);
        `CHK(nwr, 64)
        $display("test program done");
        acc(1'b1, 4'h4, 32'hf5); acc(1'b1, 4'h4, 32'h0a);
        rdc(4'hc, 32'h8);
        acc(1'b1, 4'h8, 32'h03);
        repeat (8) @(posedge i_clk);
        rdc(4'hc, 32'h0);
        $display("test both flags done");
        run(32'h1a, 1'b1);
        repeat (4) @(posedge i_clk);
        `CHK(seen, 1'b1)
        `CHK(ner, 1)
        `CHK(nwr, 64)
        $display("test erase done");
        close_out();
    end
endmodule : flash_self_program_sequencer_tb
